// *** shared/mmac_consts.vh ***
// Purpose: Constants for the memory maintenance address control block
// Assumes: Bit numbers use the machine convention, bit 0 most significant
// Notes:   Widths are given with the address, mask and reset constants; no processes live here
`ifndef MMAC_CONSTS_VH
`define MMAC_CONSTS_VH

// Maintenance channel two word, bit positions (bit 0 is the MSB)
`define MMAC_MM_PAR_DIS0 4
`define MMAC_MM_PAR_DIS1 5
`define MMAC_MM_PAR_DIS2 6
`define MMAC_MM_PAR_DIS3 7
`define MMAC_MM_STOP_IO 8
`define MMAC_MM_SWAP_SMALL 12
`define MMAC_MM_PHASE16 13
`define MMAC_MM_SWAP_MID 14
`define MMAC_MM_SWAP_HALVES 15

// Maintenance channel three word, bit positions
`define MMAC_TC_ABS_ADDR 0
`define MMAC_TC_ASSOC_TEST 1

// Address bits touched by the controls, machine bit numbers
`define MMAC_ABIT_SWAP_SMALL 40
`define MMAC_ABIT_SWAP_MID 50
`define MMAC_ABIT_SWAP_HALVES 38
`define MMAC_ABIT_ASSOC_TEST 30
// Bit pair exchanged by sixteen-bank interleave
`define MMAC_ABIT_PH16_A 50
`define MMAC_ABIT_PH16_B 39
// The two bits naming a 262K block, most significant first
`define MMAC_ABIT_BLOCK_HI 38
`define MMAC_ABIT_BLOCK_LO 39

// Associative register test store address and offset field
`define MMAC_ASSOC_TEST_BASE 64'h0000_0000_0002_4000
`define MMAC_ASSOC_OFS_MASK 64'h0000_0000_0000_0fff

// Reset values of the stored control bits
`define MMAC_MM_RESET 16'h0000
`define MMAC_TC_RESET 16'h0000

`endif

// *** core/mmac_sync3.v ***
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Input is asynchronous to i_sys_clk
// Notes:   Output changes only when stages two and three agree
`timescale 1ns/100ps
module mmac_sync3
#(
    parameter WIDTH = 1
)
(
    input wire i_sys_clk,
    input wire i_reset_n,
    input wire [WIDTH-1:0] i_async,
    output wire [WIDTH-1:0] o_level
);
    reg [WIDTH-1:0] meta_q; // First stage, read only by second
    reg [WIDTH-1:0] s2_q; // Second stage
    reg [WIDTH-1:0] s3_q; // Third stage
    reg [WIDTH-1:0] level_q; // Filtered level
    reg [WIDTH-1:0] level_d;
    integer k;

    // Accept a bit once the last two stages agree
    always @*
    begin
        level_d = level_q;
        for (k = 0; k < WIDTH; k = k + 1)
        begin
            if (s2_q[k] == s3_q[k])
            begin
                level_d[k] = s3_q[k];
            end
        end
    end

    // Shift chain and filtered level
    always @(posedge i_sys_clk)
    begin
        if (!i_reset_n)
        begin
            meta_q <= {WIDTH{1'b0}};
            s2_q <= {WIDTH{1'b0}};
            s3_q <= {WIDTH{1'b0}};
            level_q <= {WIDTH{1'b0}};
        end
        else
        begin
            meta_q <= i_async;
            s2_q <= meta_q;
            s3_q <= s2_q;
            level_q <= level_d;
        end
    end

    assign o_level = level_q;
endmodule // mmac_sync3

// *** core/mmac_addr_map.v ***
// Purpose: Combinational maintenance address mapping
// Assumes: Addresses are bit addresses, bit 0 most significant
// Notes:   Swaps apply as XOR first, then the interleave exchange
`timescale 1ns/100ps
`include "mmac_consts.vh"
module mmac_addr_map
#(
    parameter ADDR_W = 64
)
(
    input wire [ADDR_W-1:0] i_virt_addr,
    input wire [ADDR_W-1:0] i_xlate_addr,
    input wire i_assoc_store,
    input wire i_abs_mode,
    input wire i_assoc_test,
    input wire i_swap_small,
    input wire i_swap_mid,
    input wire i_swap_halves,
    input wire i_phase16,
    output reg [ADDR_W-1:0] o_abs_addr,
    output reg [ADDR_W-1:0] o_phys_addr
);
    // Machine bit n sits at vector index ADDR_W-1-n
    localparam IX_SMALL = ADDR_W - 1 - `MMAC_ABIT_SWAP_SMALL;
    localparam IX_MID = ADDR_W - 1 - `MMAC_ABIT_SWAP_MID;
    localparam IX_HALVES = ADDR_W - 1 - `MMAC_ABIT_SWAP_HALVES;
    localparam IX_ASSOC = ADDR_W - 1 - `MMAC_ABIT_ASSOC_TEST;
    localparam IX_PH_A = ADDR_W - 1 - `MMAC_ABIT_PH16_A;
    localparam IX_PH_B = ADDR_W - 1 - `MMAC_ABIT_PH16_B;

    reg [ADDR_W-1:0] sel_addr; // Translated or absolute source
    reg [ADDR_W-1:0] swp_addr; // After the toggles
    reg [ADDR_W-1:0] base_w; // Assoc test base at this width
    reg [ADDR_W-1:0] ofs_w; // Assoc test offset mask

    // Build the absolute and physical addresses
    always @*
    begin
        base_w = `MMAC_ASSOC_TEST_BASE;
        ofs_w = `MMAC_ASSOC_OFS_MASK;
        // Forced absolute skips translation
        sel_addr = i_abs_mode ? i_virt_addr : i_xlate_addr;
        swp_addr = sel_addr;
        if (i_assoc_store && i_assoc_test)
        begin
            // 2K select toggles on assoc stores only
            swp_addr[IX_ASSOC] = ~swp_addr[IX_ASSOC];
            // Assoc store lands at the fixed test area
            swp_addr = base_w | (swp_addr & ofs_w);
        end
        o_abs_addr = swp_addr;
        // Block swaps as XOR on the named bit
        if (i_swap_small)
        begin
            swp_addr[IX_SMALL] = ~swp_addr[IX_SMALL];
        end
        if (i_swap_mid)
        begin
            swp_addr[IX_MID] = ~swp_addr[IX_MID];
        end
        if (i_swap_halves)
        begin
            swp_addr[IX_HALVES] = ~swp_addr[IX_HALVES];
        end
        o_phys_addr = swp_addr;
        // Sixteen-bank interleave exchanges a bit pair
        if (i_phase16)
        begin
            o_phys_addr[IX_PH_A] = swp_addr[IX_PH_B];
            o_phys_addr[IX_PH_B] = swp_addr[IX_PH_A];
        end
    end
endmodule // mmac_addr_map

// *** core/mmac_top.v ***
// Purpose: Memory maintenance address control for the CPU
// Assumes: Channel words and strobes arrive asynchronously from the
//          maintenance unit; all other inputs are on i_sys_clk
// Notes:   Control words are write-only; their state shows on outputs
`timescale 1ns/100ps
`include "mmac_consts.vh"

// Overview of operation
// - Bits 4-7 disable parity per 262K block
// - Parity ranges decode from absolute, unswapped addresses
// - Stop bit halts CPU on I/O parity
// - Bit C toggles address bit 40
// - Bit D selects sixteen-bank interleave
// - Bit E toggles address bit 50
// - Bit F toggles address bit 38
// - Test bit 0 forces absolute addressing
// - Test bit 1 sends assoc stores to the test area; the bit 30 toggle is masked off
// - Assoc test stores go to address 24000 hex
module mmac_top
#(
    parameter ADDR_W = 64
)
(
    input wire i_sys_clk,
    input wire i_reset_n,
    input wire [15:0] i_chan_two_data,
    input wire i_chan_two_strobe,
    input wire [15:0] i_chan_three_data,
    input wire i_chan_three_strobe,
    input wire i_ref_valid,
    input wire [ADDR_W-1:0] i_ref_virt_addr,
    input wire [ADDR_W-1:0] i_ref_xlate_addr,
    input wire i_ref_assoc_store,
    input wire i_par_err,
    input wire i_par_to_io,
    input wire [ADDR_W-1:0] i_par_abs_addr,
    input wire i_halt_clear,
    output reg o_mem_valid_q,
    output reg [ADDR_W-1:0] o_mem_abs_addr_q,
    output reg [ADDR_W-1:0] o_mem_phys_addr_q,
    output reg o_parity_fault_q,
    output reg o_cpu_halt_q,
    output reg [3:0] o_par_dis_q,
    output reg o_stop_io_q,
    output reg o_swap_small_blocks_q,
    output reg o_phase16_q,
    output reg o_swap_mid_blocks_q,
    output reg o_swap_memory_halves_q,
    output reg o_abs_mode_q,
    output reg o_assoc_test_q
);
    // Machine bit n of a 16-bit word sits at index 15-n
    localparam W_PD0 = 15 - `MMAC_MM_PAR_DIS0;
    localparam W_PD1 = 15 - `MMAC_MM_PAR_DIS1;
    localparam W_PD2 = 15 - `MMAC_MM_PAR_DIS2;
    localparam W_PD3 = 15 - `MMAC_MM_PAR_DIS3;
    localparam W_STOP = 15 - `MMAC_MM_STOP_IO;
    localparam W_SSM = 15 - `MMAC_MM_SWAP_SMALL;
    localparam W_PH16 = 15 - `MMAC_MM_PHASE16;
    localparam W_SMID = 15 - `MMAC_MM_SWAP_MID;
    localparam W_SHLF = 15 - `MMAC_MM_SWAP_HALVES;
    localparam W_ABS = 15 - `MMAC_TC_ABS_ADDR;
    localparam W_ASC = 15 - `MMAC_TC_ASSOC_TEST;
    // Block number bits inside an address vector
    localparam IX_BHI = ADDR_W - 1 - `MMAC_ABIT_BLOCK_HI;
    localparam IX_BLO = ADDR_W - 1 - `MMAC_ABIT_BLOCK_LO;
    // Mask of the bits that the channel two word really stores
    localparam [15:0] MM_KEEP = (16'h0001 << W_PD0) | (16'h0001 << W_PD1)
        | (16'h0001 << W_PD2) | (16'h0001 << W_PD3)
        | (16'h0001 << W_STOP) | (16'h0001 << W_SSM)
        | (16'h0001 << W_PH16) | (16'h0001 << W_SMID)
        | (16'h0001 << W_SHLF);
    // Mask of the bits that the channel three word stores
    localparam [15:0] TC_KEEP = (16'h0001 << W_ABS) | (16'h0001 << W_ASC);

    wire [15:0] two_data_s; // Synchronised channel two word
    wire [15:0] three_data_s; // Synchronised channel three word
    wire [1:0] strobe_s; // Synchronised strobes
    reg [1:0] strobe_prev_q; // Strobe levels one cycle ago
    wire two_load; // Channel two load pulse
    wire three_load; // Channel three load pulse
    reg [15:0] mm_word_q; // Stored maintenance word
    reg [15:0] mm_word_d;
    reg [15:0] tc_word_q; // Stored test-control word
    reg [15:0] tc_word_d;
    wire [ADDR_W-1:0] map_abs; // Absolute address from mapper
    wire [ADDR_W-1:0] map_phys; // Physical address from mapper
    wire [1:0] par_block; // Block of the faulting address
    reg par_block_dis; // Parity check off for that block
    reg fault_live; // Fault survives the block disable
    reg halt_d; // Next halt state

    // Channel word synchronisers
    mmac_sync3
    #(
        .WIDTH(16)
    )
    u_sync_two
    (
        .i_sys_clk(i_sys_clk),
        .i_reset_n(i_reset_n),
        .i_async(i_chan_two_data),
        .o_level(two_data_s)
    );

    mmac_sync3
    #(
        .WIDTH(16)
    )
    u_sync_three
    (
        .i_sys_clk(i_sys_clk),
        .i_reset_n(i_reset_n),
        .i_async(i_chan_three_data),
        .o_level(three_data_s)
    );

    // Strobe synchroniser, both channels together
    mmac_sync3
    #(
        .WIDTH(2)
    )
    u_sync_strobe
    (
        .i_sys_clk(i_sys_clk),
        .i_reset_n(i_reset_n),
        .i_async({i_chan_three_strobe, i_chan_two_strobe}),
        .o_level(strobe_s)
    );

    // Remember filtered strobes for edge detection
    always @(posedge i_sys_clk)
    begin
        if (!i_reset_n)
        begin
            strobe_prev_q <= 2'b00;
        end
        else
        begin
            strobe_prev_q <= strobe_s;
        end
    end

    // A word loads on the rising edge of its filtered strobe
    assign two_load = strobe_s[0] & ~strobe_prev_q[0];
    assign three_load = strobe_s[1] & ~strobe_prev_q[1];

    // Next values of the control words
    always @*
    begin
        mm_word_d = mm_word_q;
        tc_word_d = tc_word_q;
        if (two_load)
        begin
            // Unused bits 0-3, 9, A, B never stored
            mm_word_d = two_data_s & MM_KEEP;
        end
        if (three_load)
        begin
            // Only the two test bits are kept
            tc_word_d = three_data_s & TC_KEEP;
        end
    end

    // Control word registers
    always @(posedge i_sys_clk)
    begin
        if (!i_reset_n)
        begin
            mm_word_q <= `MMAC_MM_RESET;
            tc_word_q <= `MMAC_TC_RESET;
        end
        else
        begin
            mm_word_q <= mm_word_d;
            tc_word_q <= tc_word_d;
        end
    end

    // Address mapping from the live control bits
    mmac_addr_map
    #(
        .ADDR_W(ADDR_W)
    )
    u_addr_map
    (
        .i_virt_addr(i_ref_virt_addr),
        .i_xlate_addr(i_ref_xlate_addr),
        .i_assoc_store(i_ref_assoc_store),
        .i_abs_mode(tc_word_q[W_ABS]),
        .i_assoc_test(tc_word_q[W_ASC]),
        .i_swap_small(mm_word_q[W_SSM]),
        .i_swap_mid(mm_word_q[W_SMID]),
        .i_swap_halves(mm_word_q[W_SHLF]),
        .i_phase16(mm_word_q[W_PH16]),
        .o_abs_addr(map_abs),
        .o_phys_addr(map_phys)
    );

    // Block number taken from the absolute address
    assign par_block = {i_par_abs_addr[IX_BHI], i_par_abs_addr[IX_BLO]};

    // Parity disable lookup and halt decision
    always @*
    begin
        // One disable bit per 262K block
        case (par_block)
            2'h0:
            begin
                par_block_dis = mm_word_q[W_PD0];
            end
            2'h1:
            begin
                par_block_dis = mm_word_q[W_PD1];
            end
            2'h2:
            begin
                par_block_dis = mm_word_q[W_PD2];
            end
            default:
            begin
                par_block_dis = mm_word_q[W_PD3];
            end
        endcase
        fault_live = i_par_err & ~par_block_dis;
        halt_d = o_cpu_halt_q;
        if (i_halt_clear)
        begin
            // Restart clears the halt
            halt_d = 1'b0;
        end
        if (fault_live && i_par_to_io && mm_word_q[W_STOP])
        begin
            // New I/O fault beats a clear
            halt_d = 1'b1;
        end
    end

    // Registered outputs
    always @(posedge i_sys_clk)
    begin
        if (!i_reset_n)
        begin
            o_mem_valid_q <= 1'b0;
            o_mem_abs_addr_q <= {ADDR_W{1'b0}};
            o_mem_phys_addr_q <= {ADDR_W{1'b0}};
            o_parity_fault_q <= 1'b0;
            o_cpu_halt_q <= 1'b0;
        end
        else
        begin
            o_mem_valid_q <= i_ref_valid;
            // Address only follows a valid reference
            if (i_ref_valid)
            begin
                o_mem_abs_addr_q <= map_abs;
                o_mem_phys_addr_q <= map_phys;
            end
            o_parity_fault_q <= fault_live;
            o_cpu_halt_q <= halt_d;
        end
    end

    // Visible copies of the stored control bits
    always @(posedge i_sys_clk)
    begin
        if (!i_reset_n)
        begin
            o_par_dis_q <= 4'h0;
            o_stop_io_q <= 1'b0;
            o_swap_small_blocks_q <= 1'b0;
            o_phase16_q <= 1'b0;
            o_swap_mid_blocks_q <= 1'b0;
            o_swap_memory_halves_q <= 1'b0;
            o_abs_mode_q <= 1'b0;
            o_assoc_test_q <= 1'b0;
        end
        else
        begin
            o_par_dis_q <= {mm_word_q[W_PD3], mm_word_q[W_PD2],
                mm_word_q[W_PD1], mm_word_q[W_PD0]};
            o_stop_io_q <= mm_word_q[W_STOP];
            o_swap_small_blocks_q <= mm_word_q[W_SSM];
            o_phase16_q <= mm_word_q[W_PH16];
            o_swap_mid_blocks_q <= mm_word_q[W_SMID];
            o_swap_memory_halves_q <= mm_word_q[W_SHLF];
            o_abs_mode_q <= tc_word_q[W_ABS];
            o_assoc_test_q <= tc_word_q[W_ASC];
        end
    end
endmodule // mmac_top

// *** tb/mmac_top_sva.sv ***
// Purpose: Port assertions for the maintenance address control
// Assumes: Controls are steady around references and parity faults
// Notes:   Machine address bit n sits at index ADDR_W-1-n
`timescale 1ns/100ps
module mmac_top_sva
#(
    parameter ADDR_W = 64
)
(
    input wire i_sys_clk,
    input wire i_reset_n,
    input wire i_ref_valid,
    input wire [ADDR_W-1:0] i_ref_virt_addr,
    input wire [ADDR_W-1:0] i_ref_xlate_addr,
    input wire i_ref_assoc_store,
    input wire i_par_err,
    input wire i_par_to_io,
    input wire [ADDR_W-1:0] i_par_abs_addr,
    input wire i_halt_clear,
    input wire o_mem_valid_q,
    input wire [ADDR_W-1:0] o_mem_abs_addr_q,
    input wire [ADDR_W-1:0] o_mem_phys_addr_q,
    input wire o_parity_fault_q,
    input wire o_cpu_halt_q,
    input wire [3:0] o_par_dis_q,
    input wire o_stop_io_q,
    input wire o_swap_small_blocks_q,
    input wire o_phase16_q,
    input wire o_swap_mid_blocks_q,
    input wire o_swap_memory_halves_q,
    input wire o_abs_mode_q,
    input wire o_assoc_test_q
);
    localparam int B38 = ADDR_W - 39; // Index of machine bit 38
    localparam int B39 = ADDR_W - 40; // Index of machine bit 39
    localparam int B40 = ADDR_W - 41; // Index of machine bit 40
    localparam int B50 = ADDR_W - 51; // Index of machine bit 50
    wire [ADDR_W-1:0] ab = o_mem_abs_addr_q; // Short alias
    wire [ADDR_W-1:0] ph = o_mem_phys_addr_q; // Short alias
    wire [ADDR_W-1:0] sel = o_abs_mode_q ? i_ref_virt_addr : i_ref_xlate_addr;
    wire [1:0] blk = i_par_abs_addr[B38:B39]; // Faulting block number
    wire dis = o_par_dis_q[blk]; // Parity check off for that block
    wire io_f = i_par_err && i_par_to_io && o_stop_io_q && !dis;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_reset_n);
    // Reference taken, then echoed with its addresses
    sequence s_ref;
        i_ref_valid ##1 o_mem_valid_q;
    endsequence
    // Qualified I/O parity fault
    sequence s_io_fault;
        io_f;
    endsequence
    a_ref_echo: assert property (
        ##1 o_mem_valid_q == $past(i_ref_valid))
        else $error("reference valid not echoed");
    a_fault_block: assert property (
        ##1 o_parity_fault_q == ($past(i_par_err) && !$past(dis)))
        else $error("parity fault wrong for block");
    a_io_halt: assert property (s_io_fault |=> o_cpu_halt_q)
        else $error("no halt on I/O parity fault");
    a_halt_cause: assert property (
        $rose(o_cpu_halt_q) |-> $past(io_f))
        else $error("halt without cause");
    a_halt_hold: assert property (
        o_cpu_halt_q && !i_halt_clear |=> o_cpu_halt_q)
        else $error("halt dropped without clear");
    a_swap_small: assert property (
        s_ref |-> ph[B40] == (ab[B40] ^ $past(o_swap_small_blocks_q, 1)))
        else $error("bit 40 swap wrong");
    a_swap_halves: assert property (
        s_ref |-> ph[B38] == (ab[B38] ^ $past(o_swap_memory_halves_q, 1)))
        else $error("bit 38 swap wrong");
    a_swap_mid: assert property (s_ref |-> ph[B50] ==
        ($past(o_phase16_q, 1) ? ab[B39]
        : ab[B50] ^ $past(o_swap_mid_blocks_q, 1)))
        else $error("bit 50 wrong");
    a_phase_pair: assert property (s_ref |-> ph[B39] ==
        ($past(o_phase16_q, 1) ? ab[B50] ^ $past(o_swap_mid_blocks_q, 1)
        : ab[B39]))
        else $error("bit 39 wrong");
    a_abs_select: assert property (
        i_ref_valid && !(o_assoc_test_q && i_ref_assoc_store)
        |=> ab == $past(sel))
        else $error("absolute address wrong");
    a_assoc_store: assert property (
        i_ref_valid && o_assoc_test_q && i_ref_assoc_store |=> ab ==
        (ADDR_W'(20'h24000) | ($past(sel) & ADDR_W'(12'hfff))))
        else $error("associative store address wrong");
endmodule // mmac_top_sva

bind mmac_top mmac_top_sva #(.ADDR_W(ADDR_W)) mmac_top_sva_inst (
    .i_sys_clk, .i_reset_n, .i_ref_valid, .i_ref_virt_addr,
    .i_ref_xlate_addr, .i_ref_assoc_store, .i_par_err, .i_par_to_io,
    .i_par_abs_addr, .i_halt_clear, .o_mem_valid_q, .o_mem_abs_addr_q,
    .o_mem_phys_addr_q, .o_parity_fault_q, .o_cpu_halt_q, .o_par_dis_q,
    .o_stop_io_q, .o_swap_small_blocks_q, .o_phase16_q,
    .o_swap_mid_blocks_q, .o_swap_memory_halves_q, .o_abs_mode_q,
    .o_assoc_test_q);

// *** tb/mmac_maint_unit.sv ***
// Purpose: Maintenance unit model driving both channel words
// Assumes: Words are levels qualified by a rising strobe
// Notes:   Data flips once the strobe drops, so stale words show up
`timescale 1ns/100ps
module mmac_maint_unit
(
    input wire i_sys_clk,
    output logic [15:0] o_two_data,
    output logic o_two_strobe,
    output logic [15:0] o_three_data,
    output logic o_three_strobe
);
    // Idle levels at time zero
    initial
    begin
        o_two_data = 16'h0000;
        o_two_strobe = 1'b0;
        o_three_data = 16'h0000;
        o_three_strobe = 1'b0;
    end
    // One word; sel picks channel three; bit n of the word is index 15-n
    task send(input logic sel, input logic [15:0] w);
        begin
            @(posedge i_sys_clk) #1;
            o_two_data = sel ? o_two_data : w;
            o_three_data = sel ? w : o_three_data;
            repeat (6) @(posedge i_sys_clk);
            #1 o_two_strobe = !sel;
            o_three_strobe = sel;
            repeat (8) @(posedge i_sys_clk);
            #1 o_two_strobe = 1'b0;
            o_three_strobe = 1'b0;
            o_two_data = sel ? o_two_data : ~w;
            o_three_data = sel ? ~w : o_three_data;
            repeat (6) @(posedge i_sys_clk);
            // Step off the edge so callers read settled outputs
            #1;
        end
    endtask
endmodule // mmac_maint_unit

// *** tb/mmac_top_tb.sv ***
// Purpose: Self-checking bench for the maintenance address control
// Assumes: Control words settle before any reference or fault
// Notes:   Address bit n of the machine is index 63-n
`timescale 1ns/100ps
module mmac_top_tb;
    integer num_errors = 0; // Mismatch count
    integer n_checks = 0; // Comparison count
    integer k, j; // Loop indices
    logic i_sys_clk;
    logic i_reset_n;
    logic rv, st, pe, pio, hc; // Reference and parity strobes
    logic [63:0] va, xa, pa, a, e; // Addresses and expectations
    logic [15:0] w; // Channel word under test
    wire [15:0] d2, d3; // Channel words
    wire s2, s3; // Channel strobes
    wire mv, pf, ht, sp, c, dd, ee, f, ab, at; // Output levels
    wire [63:0] aq, pq; // Registered addresses
    wire [3:0] pd; // Parity disables
    wire [10:0] cv = {pd, sp, c, dd, ee, f, ab, at}; // Stored controls
    mmac_top mmac_top_inst (
        .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
        .i_chan_two_data(d2), .i_chan_two_strobe(s2),
        .i_chan_three_data(d3), .i_chan_three_strobe(s3),
        .i_ref_valid(rv), .i_ref_virt_addr(va), .i_ref_xlate_addr(xa),
        .i_ref_assoc_store(st), .i_par_err(pe), .i_par_to_io(pio),
        .i_par_abs_addr(pa), .i_halt_clear(hc), .o_mem_valid_q(mv),
        .o_mem_abs_addr_q(aq), .o_mem_phys_addr_q(pq),
        .o_parity_fault_q(pf), .o_cpu_halt_q(ht), .o_par_dis_q(pd),
        .o_stop_io_q(sp), .o_swap_small_blocks_q(c), .o_phase16_q(dd),
        .o_swap_mid_blocks_q(ee), .o_swap_memory_halves_q(f),
        .o_abs_mode_q(ab), .o_assoc_test_q(at));
    mmac_maint_unit mmac_maint_unit_inst (.i_sys_clk(i_sys_clk),
        .o_two_data(d2), .o_two_strobe(s2), .o_three_data(d3),
        .o_three_strobe(s3));
    // 200 MHz clock
    initial
    begin
        i_sys_clk = 1'b0;
        forever #2.5 i_sys_clk = ~i_sys_clk;
    end
    // Compare and count
    task chk(input logic [63:0] got, input logic [63:0] exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp)
            begin
                num_errors = num_errors + 1;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    // One reference, checked for its echo
    task mref(input logic [63:0] v, input logic [63:0] x, input logic s);
        begin
            @(posedge i_sys_clk) #1;
            va = v;
            xa = x;
            st = s;
            rv = 1'b1;
            @(posedge i_sys_clk) #1;
            rv = 1'b0;
            chk({63'h0, mv}, 64'h1);
        end
    endtask
    // One parity fault pulse
    task mpar(input logic [63:0] x, input logic io);
        begin
            @(posedge i_sys_clk) #1;
            pa = x;
            pio = io;
            pe = 1'b1;
            @(posedge i_sys_clk) #1;
            pe = 1'b0;
        end
    endtask
    // Expected physical address; s is {C, D, E, F}
    function automatic logic [63:0] map(input logic [63:0] x,
        input logic [3:0] s);
        logic t;
        begin
            x[23] = x[23] ^ s[3];
            x[13] = x[13] ^ s[1];
            x[25] = x[25] ^ s[0];
            t = x[13];
            x[13] = s[2] ? x[24] : x[13];
            x[24] = s[2] ? t : x[24];
            map = x;
        end
    endfunction
    // Counts, verdict, stop
    task end_of_test;
        begin
            $display("checks %0d mismatches %0d", n_checks, num_errors);
            if (num_errors == 0 && n_checks > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    // Hang guard, well past the expected run
    initial
    begin
        #200000;
        num_errors = num_errors + 1;
        end_of_test;
    end
    // Main sequence
    initial
    begin
        i_reset_n = 1'b0;
        {rv, st, pe, pio, hc} = 5'h00;
        {va, xa, pa} = 192'h0;
        repeat (2) @(posedge i_sys_clk);
        #1 i_reset_n = 1'b1;
        chk({53'h0, cv}, 64'h0);
        $display("test reset done");
        for (k = 0; k < 16; k = k + 1)
        begin
            w = 16'h8000 >> k;
            mmac_maint_unit_inst.send(1'b0, w);
            chk({53'h0, cv}, {53'h0, w[8], w[9], w[10], w[11], w[7],
                w[3:0], 2'b00});
        end
        mmac_maint_unit_inst.send(1'b0, 16'h0000);
        for (k = 0; k < 3; k = k + 1)
        begin
            w = 16'h8000 >> k;
            mmac_maint_unit_inst.send(1'b1, w);
            chk({53'h0, cv}, {62'h0, w[15:14]});
        end
        mmac_maint_unit_inst.send(1'b1, 16'h0000);
        $display("test control words done");
        for (k = 0; k < 16; k = k + 1)
        begin
            a = {16{k[3:0]}} ^ 64'h0123456789abcdef;
            mmac_maint_unit_inst.send(1'b0, {12'h000, k[3:0]});
            mref(~a, a, 1'b1);
            chk(aq, a);
            chk(pq, map(a, k[3:0]));
        end
        mmac_maint_unit_inst.send(1'b0, 16'h0000);
        $display("test swaps done");
        for (k = 0; k < 4; k = k + 1)
        begin
            mmac_maint_unit_inst.send(1'b1, {k[1:0], 14'h0000});
            for (j = 0; j < 2; j = j + 1)
            begin
                mref(a, ~a, j[0]);
                e = k[1] ? a : ~a;
                e = (k[0] && j[0]) ? 64'h24000 | (e & 64'hfff) : e;
                chk(aq, e);
                chk(pq, e);
            end
        end
        mmac_maint_unit_inst.send(1'b1, 16'h0000);
        $display("test absolute and test modes done");
        mmac_maint_unit_inst.send(1'b0, 16'h0280);
        for (k = 0; k < 8; k = k + 1)
        begin
            mpar({38'h0, k[2:1], 24'h0}, k[0]);
            chk({62'h0, pf, ht}, {62'h0, k[2:1] != 2'd2,
                k[0] && k[2:1] != 2'd2});
            @(posedge i_sys_clk) #1 hc = 1'b1;
            @(posedge i_sys_clk) #1 hc = 1'b0;
            chk({63'h0, ht}, 64'h0);
        end
        mmac_maint_unit_inst.send(1'b0, 16'h0000);
        mpar(64'h0, 1'b1);
        chk({62'h0, pf, ht}, 64'h2);
        $display("test parity done");
        end_of_test;
    end
endmodule // mmac_top_tb
